// *** rtl/lsc_regs.sv ***
/*
  Lane-1 signal conditioning register bank: equalizer and idle threshold
  settings of input paths A and B, output idle control and output swing.
  Assumes a management-bus engine that presents byte writes and reads
  synchronous to REF_CLK, and an analog idle detector flag on the same clock.
*/
`include "lsc_cfg.svh"

// Notes on behaviour
// - equalizer field: bit 5 enable, bits 4:3 gain, bits 2:0 boost.
// - equalizer fields reset to 20 hex, which is bypass.
// - three gain stages times eight boost steps give 24 levels.
// - idle threshold bits 3:2 de-assert, bits 1:0 assert.
// - idle thresholds reset to 00, higher codes raise both levels.
// - output bit 5 set means automatic idle, clear means manual.
// - manual control with bit 4 set mutes the output.
// - manual control with bit 4 clear drives, signal detect off.
// - first swing code is 7 bits, resets to 03, 07 is high.
// - second swing register is 8 bits and resets to 03 hex.
// - paths A and B have separate equalizer and threshold registers.
module lsc_regs
  import lsc_pkg::*;
(
  // clock and reset
  input wire logic REF_CLK,
  input wire logic RST_N,
  // register access from the bus engine
  input wire logic [7:0] REG_ADDR,
  input wire logic REG_WR_EN,
  input wire lsc_byte_t REG_WR_DATA,
  input wire logic REG_RD_EN,
  output lsc_byte_t REG_RD_DATA,
  output logic REG_RD_VALID,
  // idle detector of the selected lane-1 input
  input wire logic INPUT_IDLE_DETECTED,
  // input path A equalizer and idle detector
  output logic INPUT_A_LANE1_EQ_ENABLE,
  output logic [1:0] INPUT_A_LANE1_GAIN_STAGE_CODE,
  output logic [2:0] INPUT_A_LANE1_BOOST_LEVEL_CODE,
  output logic [4:0] INPUT_A_LANE1_EQ_LEVEL,
  output logic INPUT_A_LANE1_EQ_LEVEL_VALID,
  output logic INPUT_A_LANE1_EQ_BYPASS,
  output logic [1:0] INPUT_A_LANE1_DEASSERT_THR,
  output logic [1:0] INPUT_A_LANE1_ASSERT_THR,
  // input path B equalizer and idle detector
  output logic INPUT_B_LANE1_EQ_ENABLE,
  output logic [1:0] INPUT_B_LANE1_GAIN_STAGE_CODE,
  output logic [2:0] INPUT_B_LANE1_BOOST_LEVEL_CODE,
  output logic [4:0] INPUT_B_LANE1_EQ_LEVEL,
  output logic INPUT_B_LANE1_EQ_LEVEL_VALID,
  output logic INPUT_B_LANE1_EQ_BYPASS,
  output logic [1:0] INPUT_B_LANE1_DEASSERT_THR,
  output logic [1:0] INPUT_B_LANE1_ASSERT_THR,
  // output driver
  output logic OUTPUT_LANE1_MUTE,
  output logic OUTPUT_LANE1_SIGNAL_DETECT_EN,
  output logic [6:0] OUTPUT_LANE1_SWING_FIRST,
  output logic OUTPUT_LANE1_SWING_HIGH,
  output lsc_byte_t OUTPUT_LANE1_SWING_SECOND
);

  lsc_byte_t input_a_lane1_equalizer;
  lsc_byte_t input_a_lane1_idle_threshold;
  lsc_byte_t output_lane1_idle_select;
  lsc_byte_t input_b_lane1_equalizer;
  lsc_byte_t output_lane1_swing_first;
  lsc_byte_t output_lane1_swing_second;
  lsc_byte_t input_b_lane1_idle_threshold;
  lsc_byte_t next_rd_data;
  lsc_idle_src_e idle_src;

  function automatic logic hit(input logic [7:0] ofs);
    hit = REG_WR_EN && (REG_ADDR == ofs);
  endfunction

  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
      input_a_lane1_equalizer <= `LSC_RST_EQ;
    else if (hit(`LSC_OFS_IN_A_EQ))
      input_a_lane1_equalizer <= REG_WR_DATA;
  end

  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
      input_b_lane1_equalizer <= `LSC_RST_EQ;
    else if (hit(`LSC_OFS_IN_B_EQ))
      input_b_lane1_equalizer <= REG_WR_DATA;
  end

  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      input_a_lane1_idle_threshold <= `LSC_RST_IDLE_THR;
      input_b_lane1_idle_threshold <= `LSC_RST_IDLE_THR;
    end
    else
    begin
      if (hit(`LSC_OFS_IN_A_IDLE_THR))
        input_a_lane1_idle_threshold <= REG_WR_DATA;
      if (hit(`LSC_OFS_IN_B_IDLE_THR))
        input_b_lane1_idle_threshold <= REG_WR_DATA;
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
      output_lane1_idle_select <= `LSC_RST_IDLE_SEL;
    else if (hit(`LSC_OFS_OUT_IDLE_SEL))
      output_lane1_idle_select <= REG_WR_DATA;
  end

  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      output_lane1_swing_first <= `LSC_RST_SWING_1;
      output_lane1_swing_second <= `LSC_RST_SWING_2;
    end
    else
    begin
      if (hit(`LSC_OFS_OUT_SWING_1))
        output_lane1_swing_first <= REG_WR_DATA;
      if (hit(`LSC_OFS_OUT_SWING_2))
        output_lane1_swing_second <= REG_WR_DATA;
    end
  end

  // read mux; a read in the cycle of a write returns the old value
  always_comb
  begin
    next_rd_data = `LSC_RST_UNMAPPED;
    case (REG_ADDR)
      `LSC_OFS_IN_A_EQ: next_rd_data = input_a_lane1_equalizer;
      `LSC_OFS_IN_A_IDLE_THR: next_rd_data = input_a_lane1_idle_threshold;
      `LSC_OFS_OUT_IDLE_SEL: next_rd_data = output_lane1_idle_select;
      `LSC_OFS_IN_B_EQ: next_rd_data = input_b_lane1_equalizer;
      `LSC_OFS_OUT_SWING_1: next_rd_data = output_lane1_swing_first;
      `LSC_OFS_OUT_SWING_2: next_rd_data = output_lane1_swing_second;
      `LSC_OFS_IN_B_IDLE_THR: next_rd_data = input_b_lane1_idle_threshold;
      default: next_rd_data = `LSC_RST_UNMAPPED;
    endcase
  end

  // read data holds until the next read
  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      REG_RD_DATA <= `LSC_RST_UNMAPPED;
      REG_RD_VALID <= 1'b0;
    end
    else
    begin
      REG_RD_VALID <= REG_RD_EN;
      if (REG_RD_EN)
        REG_RD_DATA <= next_rd_data;
    end
  end

  lsc_eq_decode u_eq_a
  (
    .clk(REF_CLK),
    .rst_n(RST_N),
    .eq_field(input_a_lane1_equalizer[5:0]),
    .eq_enable(INPUT_A_LANE1_EQ_ENABLE),
    .gain_stage_code(INPUT_A_LANE1_GAIN_STAGE_CODE),
    .boost_level_code(INPUT_A_LANE1_BOOST_LEVEL_CODE),
    .eq_level(INPUT_A_LANE1_EQ_LEVEL),
    .eq_level_valid(INPUT_A_LANE1_EQ_LEVEL_VALID),
    .eq_bypass(INPUT_A_LANE1_EQ_BYPASS)
  );

  lsc_eq_decode u_eq_b
  (
    .clk(REF_CLK),
    .rst_n(RST_N),
    .eq_field(input_b_lane1_equalizer[5:0]),
    .eq_enable(INPUT_B_LANE1_EQ_ENABLE),
    .gain_stage_code(INPUT_B_LANE1_GAIN_STAGE_CODE),
    .boost_level_code(INPUT_B_LANE1_BOOST_LEVEL_CODE),
    .eq_level(INPUT_B_LANE1_EQ_LEVEL),
    .eq_level_valid(INPUT_B_LANE1_EQ_LEVEL_VALID),
    .eq_bypass(INPUT_B_LANE1_EQ_BYPASS)
  );

  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      INPUT_A_LANE1_DEASSERT_THR <= 2'h0;
      INPUT_A_LANE1_ASSERT_THR <= 2'h0;
      INPUT_B_LANE1_DEASSERT_THR <= 2'h0;
      INPUT_B_LANE1_ASSERT_THR <= 2'h0;
    end
    else
    begin
      INPUT_A_LANE1_DEASSERT_THR <= input_a_lane1_idle_threshold
        [`LSC_THR_DEASSERT_HI:`LSC_THR_DEASSERT_LO];
      INPUT_A_LANE1_ASSERT_THR <= input_a_lane1_idle_threshold
        [`LSC_THR_ASSERT_HI:`LSC_THR_ASSERT_LO];
      INPUT_B_LANE1_DEASSERT_THR <= input_b_lane1_idle_threshold
        [`LSC_THR_DEASSERT_HI:`LSC_THR_DEASSERT_LO];
      INPUT_B_LANE1_ASSERT_THR <= input_b_lane1_idle_threshold
        [`LSC_THR_ASSERT_HI:`LSC_THR_ASSERT_LO];
    end
  end

  assign idle_src = lsc_idle_src_e'(
    output_lane1_idle_select[`LSC_IDLE_AUTO_BIT]);

  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      OUTPUT_LANE1_MUTE <= 1'b0;
      OUTPUT_LANE1_SIGNAL_DETECT_EN <= 1'b0;
    end
    else if (idle_src == LSC_IDLE_AUTO)
    begin
      OUTPUT_LANE1_MUTE <= INPUT_IDLE_DETECTED;
      OUTPUT_LANE1_SIGNAL_DETECT_EN <= 1'b1;
    end
    else
    begin
      OUTPUT_LANE1_MUTE <= output_lane1_idle_select[`LSC_IDLE_SEL_BIT];
      OUTPUT_LANE1_SIGNAL_DETECT_EN <= 1'b0;
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      OUTPUT_LANE1_SWING_FIRST <= 7'(`LSC_RST_SWING_1);
      OUTPUT_LANE1_SWING_HIGH <= 1'b0;
      OUTPUT_LANE1_SWING_SECOND <= `LSC_RST_SWING_2;
    end
    else
    begin
      OUTPUT_LANE1_SWING_FIRST <=
        output_lane1_swing_first[`LSC_SWING_1_HI:0];
      OUTPUT_LANE1_SWING_HIGH <= (output_lane1_swing_first
        [`LSC_SWING_1_HI:0] == `LSC_SWING_1_HIGH_CODE);
      OUTPUT_LANE1_SWING_SECOND <= output_lane1_swing_second;
    end
  end

  // first edge after release sees the reset state
  property p_reset_defaults;
    @(posedge REF_CLK) disable iff (!RST_N)
    $rose(RST_N) |-> input_a_lane1_equalizer == 8'h20
      && input_b_lane1_equalizer == 8'h20 && INPUT_A_LANE1_EQ_BYPASS
      && input_a_lane1_idle_threshold == 8'h00
      && input_b_lane1_idle_threshold == 8'h00;
  endproperty
  a_reset_defaults: assert property (p_reset_defaults)
    else $error("equalizer or threshold reset value wrong");
  property p_swing_reset;
    @(posedge REF_CLK) disable iff (!RST_N)
    $rose(RST_N) |-> OUTPUT_LANE1_SWING_FIRST == 7'h03
      && OUTPUT_LANE1_SWING_SECOND == 8'h03 && !OUTPUT_LANE1_SWING_HIGH;
  endproperty
  a_swing_reset: assert property (p_swing_reset)
    else $error("swing reset value wrong");
  property p_eq_split;
    @(posedge REF_CLK) disable iff (!RST_N)
    REG_WR_EN && REG_ADDR == 8'h1D |=> ##1
      INPUT_A_LANE1_GAIN_STAGE_CODE == $past(REG_WR_DATA[4:3], 2)
      && INPUT_A_LANE1_BOOST_LEVEL_CODE == $past(REG_WR_DATA[2:0], 2)
      && INPUT_A_LANE1_EQ_ENABLE == $past(REG_WR_DATA[5], 2);
  endproperty
  a_eq_split: assert property (p_eq_split)
    else $error("equalizer field split wrong");
  property p_path_isolation;
    @(posedge REF_CLK) disable iff (!RST_N)
    REG_WR_EN && REG_ADDR == 8'h1D |=>
      $stable(input_b_lane1_equalizer)
      && input_a_lane1_equalizer == $past(REG_WR_DATA);
  endproperty
  a_path_isolation: assert property (p_path_isolation)
    else $error("path A write disturbed path B");
  property p_thr_split;
    @(posedge REF_CLK) disable iff (!RST_N)
    REG_WR_EN && REG_ADDR == 8'h27 |=> ##1
      INPUT_B_LANE1_DEASSERT_THR == $past(REG_WR_DATA[3:2], 2)
      && INPUT_B_LANE1_ASSERT_THR == $past(REG_WR_DATA[1:0], 2);
  endproperty
  a_thr_split: assert property (p_thr_split)
    else $error("idle threshold split wrong");
  property p_auto_idle;
    @(posedge REF_CLK) disable iff (!RST_N)
    output_lane1_idle_select[5] |=>
      OUTPUT_LANE1_SIGNAL_DETECT_EN
      && OUTPUT_LANE1_MUTE == $past(INPUT_IDLE_DETECTED);
  endproperty
  a_auto_idle: assert property (p_auto_idle)
    else $error("automatic idle not followed");
  property p_manual_mute;
    @(posedge REF_CLK) disable iff (!RST_N)
    output_lane1_idle_select[5:4] == 2'h1 |=> OUTPUT_LANE1_MUTE;
  endproperty
  a_manual_mute: assert property (p_manual_mute)
    else $error("manual idle did not mute");
  property p_manual_drive;
    @(posedge REF_CLK) disable iff (!RST_N)
    output_lane1_idle_select[5:4] == 2'h0 |=>
      !OUTPUT_LANE1_MUTE && !OUTPUT_LANE1_SIGNAL_DETECT_EN;
  endproperty
  a_manual_drive: assert property (p_manual_drive)
    else $error("manual drive state wrong");
  property p_swing_high;
    @(posedge REF_CLK) disable iff (!RST_N)
    REG_WR_EN && REG_ADDR == 8'h25 |=> ##1
      OUTPUT_LANE1_SWING_HIGH == ($past(REG_WR_DATA[6:0], 2) == 7'h07);
  endproperty
  a_swing_high: assert property (p_swing_high)
    else $error("swing level decode wrong");
  property p_read_unmapped;
    @(posedge REF_CLK) disable iff (!RST_N)
    REG_RD_EN && REG_ADDR == 8'h21 |=> REG_RD_VALID && REG_RD_DATA == 8'h00;
  endproperty
  a_read_unmapped: assert property (p_read_unmapped)
    else $error("unmapped read not zero");

endmodule

// *** rtl/lsc_cfg.svh ***
/*
  Offsets, field positions, reset values and decode codes of the lane-1
  signal conditioning register bank.
  Assumes inclusion by bare name from the package and the design modules.
*/
`ifndef LSC_CFG_SVH
`define LSC_CFG_SVH

// register offsets on the management bus
`define LSC_OFS_IN_A_EQ        8'h1D
`define LSC_OFS_IN_A_IDLE_THR  8'h20
`define LSC_OFS_OUT_IDLE_SEL   8'h23
`define LSC_OFS_IN_B_EQ        8'h24
`define LSC_OFS_OUT_SWING_1    8'h25
`define LSC_OFS_OUT_SWING_2    8'h26
`define LSC_OFS_IN_B_IDLE_THR  8'h27

// reset values
`define LSC_RST_EQ             8'h20
`define LSC_RST_IDLE_THR       8'h00
`define LSC_RST_IDLE_SEL       8'h00
`define LSC_RST_SWING_1        8'h03
`define LSC_RST_SWING_2        8'h03
`define LSC_RST_UNMAPPED       8'h00

// equalizer field layout
`define LSC_EQ_EN_BIT          5
`define LSC_EQ_GAIN_HI         4
`define LSC_EQ_GAIN_LO         3
`define LSC_EQ_BOOST_HI        2
`define LSC_EQ_BOOST_LO        0
`define LSC_EQ_BYPASS_CODE     6'h20
`define LSC_EQ_GAIN_STAGES     2'h3
`define LSC_EQ_BOOST_STEPS     5'h08
`define LSC_EQ_LEVEL_MAX       5'h17

// idle threshold layout
`define LSC_THR_DEASSERT_HI    3
`define LSC_THR_DEASSERT_LO    2
`define LSC_THR_ASSERT_HI      1
`define LSC_THR_ASSERT_LO      0

// output idle select layout
`define LSC_IDLE_AUTO_BIT      5
`define LSC_IDLE_SEL_BIT       4

// output swing layout and codes
`define LSC_SWING_1_HI         6
`define LSC_SWING_1_HIGH_CODE  7'h07

`endif

// *** rtl/lsc_pkg.sv ***
/*
  Types shared by the lane-1 signal conditioning register bank.
  Assumes lsc_cfg.svh for the numeric constants.
*/
`include "lsc_cfg.svh"

package lsc_pkg;

  typedef logic [7:0] lsc_byte_t;
  typedef logic [5:0] lsc_eq_field_t;

  // where the output idle state comes from
  typedef enum logic [0:0]
  {
    LSC_IDLE_MANUAL = 1'b0,
    LSC_IDLE_AUTO = 1'b1
  } lsc_idle_src_e;

endpackage

// *** rtl/lsc_eq_decode.sv ***
/*
  Splits one input equalizer field into enable, gain stage and boost level,
  and forms the flat level index for the analog equalizer.
  Assumes a field that is steady on each clock; all outputs are registered.
*/
`include "lsc_cfg.svh"

module lsc_eq_decode
  import lsc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // field from the register bank
  input wire lsc_eq_field_t eq_field,
  // decoded settings
  output logic eq_enable,
  output logic [1:0] gain_stage_code,
  output logic [2:0] boost_level_code,
  output logic [4:0] eq_level,
  output logic eq_level_valid,
  output logic eq_bypass
);

  logic [1:0] field_gain;
  logic [2:0] field_boost;
  logic [4:0] next_level;

  assign field_gain = eq_field[`LSC_EQ_GAIN_HI:`LSC_EQ_GAIN_LO];
  assign field_boost = eq_field[`LSC_EQ_BOOST_HI:`LSC_EQ_BOOST_LO];
  assign next_level = {field_gain, field_boost};

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      eq_enable <= 1'b1;
      gain_stage_code <= 2'h0;
      boost_level_code <= 3'h0;
    end
    else
    begin
      eq_enable <= eq_field[`LSC_EQ_EN_BIT];
      gain_stage_code <= field_gain;
      boost_level_code <= field_boost;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      eq_level <= 5'h00;
      eq_level_valid <= 1'b1;
    end
    else if (field_gain == `LSC_EQ_GAIN_STAGES)
    begin
      // fourth gain code does not exist, clamp to top level
      eq_level <= `LSC_EQ_LEVEL_MAX;
      eq_level_valid <= 1'b0;
    end
    else
    begin
      eq_level <= next_level;
      eq_level_valid <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      eq_bypass <= 1'b1;
    else
      eq_bypass <= (eq_field == `LSC_EQ_BYPASS_CODE);
  end

  property p_level_index;
    @(posedge clk) disable iff (!rst_n)
    (field_gain != `LSC_EQ_GAIN_STAGES) |=>
      (eq_level == ({3'h0, $past(field_gain)} * `LSC_EQ_BOOST_STEPS
        + {2'h0, $past(field_boost)})) && eq_level_valid;
  endproperty
  a_level_index: assert property (p_level_index)
    else $error("equalizer level index wrong");

endmodule

// *** verification/lsc_host_model.sv ***
/*
  Host-side model of the management bus engine: byte write and read
  strobes into the lane-1 register bank, plus the analog idle flag.
  Assumes a free-running clock and the bank's one-cycle read answer.
*/
module lsc_host_model
  import lsc_pkg::*;
(
  // clock
  input wire logic clk,
  // register port
  output logic [7:0] reg_addr,
  output logic reg_wr_en,
  output lsc_byte_t reg_wr_data,
  output logic reg_rd_en,
  input wire lsc_byte_t reg_rd_data,
  input wire logic reg_rd_valid,
  // idle detector flag
  output logic idle_detected
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    reg_addr = 8'h00;
    reg_wr_en = 1'b0;
    reg_wr_data = 8'h00;
    reg_rd_en = 1'b0;
    idle_detected = 1'b0;
  end

  // released lines flip so a stale value never looks valid
  task automatic write_reg(input logic [7:0] addr, input lsc_byte_t data);
    @(posedge clk);
    reg_addr <= addr;
    reg_wr_data <= data;
    reg_wr_en <= 1'b1;
    @(posedge clk);
    reg_wr_en <= 1'b0;
    reg_addr <= ~addr;
    reg_wr_data <= ~data;
  endtask

  task automatic read_reg(input logic [7:0] addr, output lsc_byte_t data,
    output logic ok);
    ok = 1'b0;
    data = 8'h00;
    @(posedge clk);
    reg_addr <= addr;
    reg_rd_en <= 1'b1;
    @(posedge clk);
    reg_rd_en <= 1'b0;
    reg_addr <= ~addr;
    // bounded wait; valid stands one cycle, taken at the edge ending it
    for (int n = 0; n < 4 && ok !== 1'b1; n++)
    begin
      @(posedge clk);
      if (reg_rd_valid === 1'b1)
      begin
        data = reg_rd_data;
        ok = 1'b1;
      end
    end
  endtask

  task automatic drive_idle(input logic v);
    @(posedge clk);
    idle_detected <= v;
  endtask
endmodule

// *** verification/lsc_regs_test.sv ***
/*
  Self-checking bench of the lane-1 register bank: reset values, field
  decode, path independence, idle control, swing and unmapped offsets.
  Assumes lsc_host_model as bus engine and a 50 MHz REF_CLK.
*/
`include "lsc_cfg.svh"

module lsc_regs_test
  import lsc_pkg::*;
  ;
  timeunit 1ns;
  timeprecision 1ps;

  logic REF_CLK;
  logic RST_N;
  logic [7:0] addr;
  logic wr_en, rd_en, rd_valid, idle;
  lsc_byte_t wr_data, rd_data, sw2, bb;
  logic a_en, a_lv, a_byp, b_en, b_lv, b_byp, mute, sd_en, sw_hi;
  logic [1:0] a_gain, a_dthr, a_athr, b_gain, b_dthr, b_athr;
  logic [2:0] a_boost, b_boost;
  logic [4:0] a_lvl, b_lvl;
  logic [5:0] fa;
  logic [6:0] sw1;
  logic v, prev;
  int n_mismatch;
  int checks;
  logic [7:0] ofs [7] = '{`LSC_OFS_IN_A_EQ, `LSC_OFS_IN_A_IDLE_THR,
    `LSC_OFS_OUT_IDLE_SEL, `LSC_OFS_IN_B_EQ, `LSC_OFS_OUT_SWING_1,
    `LSC_OFS_OUT_SWING_2, `LSC_OFS_IN_B_IDLE_THR};
  logic [7:0] rst [7] = '{`LSC_RST_EQ, `LSC_RST_IDLE_THR,
    `LSC_RST_IDLE_SEL, `LSC_RST_EQ, `LSC_RST_SWING_1, `LSC_RST_SWING_2,
    `LSC_RST_IDLE_THR};
  // gain code 3, enable off, exact bypass
  logic [5:0] corner [3] = '{6'h3F, 6'h00, 6'h20};

  lsc_host_model host (.clk(REF_CLK), .reg_addr(addr), .reg_wr_en(wr_en),
    .reg_wr_data(wr_data), .reg_rd_en(rd_en), .reg_rd_data(rd_data),
    .reg_rd_valid(rd_valid), .idle_detected(idle));

  lsc_regs uut (.REF_CLK(REF_CLK), .RST_N(RST_N), .REG_ADDR(addr),
    .REG_WR_EN(wr_en), .REG_WR_DATA(wr_data), .REG_RD_EN(rd_en),
    .REG_RD_DATA(rd_data), .REG_RD_VALID(rd_valid),
    .INPUT_IDLE_DETECTED(idle), .INPUT_A_LANE1_EQ_ENABLE(a_en),
    .INPUT_A_LANE1_GAIN_STAGE_CODE(a_gain),
    .INPUT_A_LANE1_BOOST_LEVEL_CODE(a_boost),
    .INPUT_A_LANE1_EQ_LEVEL(a_lvl), .INPUT_A_LANE1_EQ_LEVEL_VALID(a_lv),
    .INPUT_A_LANE1_EQ_BYPASS(a_byp), .INPUT_A_LANE1_DEASSERT_THR(a_dthr),
    .INPUT_A_LANE1_ASSERT_THR(a_athr), .INPUT_B_LANE1_EQ_ENABLE(b_en),
    .INPUT_B_LANE1_GAIN_STAGE_CODE(b_gain),
    .INPUT_B_LANE1_BOOST_LEVEL_CODE(b_boost),
    .INPUT_B_LANE1_EQ_LEVEL(b_lvl), .INPUT_B_LANE1_EQ_LEVEL_VALID(b_lv),
    .INPUT_B_LANE1_EQ_BYPASS(b_byp), .INPUT_B_LANE1_DEASSERT_THR(b_dthr),
    .INPUT_B_LANE1_ASSERT_THR(b_athr), .OUTPUT_LANE1_MUTE(mute),
    .OUTPUT_LANE1_SIGNAL_DETECT_EN(sd_en), .OUTPUT_LANE1_SWING_FIRST(sw1),
    .OUTPUT_LANE1_SWING_HIGH(sw_hi), .OUTPUT_LANE1_SWING_SECOND(sw2));

  initial
  begin
    REF_CLK = 1'b0;
    forever #10 REF_CLK = ~REF_CLK;
  end

  task automatic close_out();
    $display("mismatches %0d checks %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp,
    input string what);
    checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_rd(input logic [7:0] a, input lsc_byte_t exp);
    lsc_byte_t d;
    logic ok;
    host.read_reg(a, d, ok);
    if (ok !== 1'b1)
    begin
      n_mismatch++;
      $display("[ERR] %0t read of %h never answered", $time, a);
      close_out();
    end
    else
      chk(16'(d), 16'(exp), "read back");
  endtask

  // enable, gain, boost, flat level, level valid, bypass
  function automatic logic [12:0] exp_eq(input logic [5:0] f);
    logic three;
    three = (f[4:3] == 2'h3);
    return {f, three ? 5'h17 : {3'h0, f[4:3]} * 5'h08 + {2'h0, f[2:0]},
      !three, f == 6'h20};
  endfunction

  task automatic chk_eq(input logic [5:0] ea, input logic [5:0] eb);
    chk(16'({a_en, a_gain, a_boost, a_lvl, a_lv, a_byp}), 16'(exp_eq(ea)),
      "eq a");
    chk(16'({b_en, b_gain, b_boost, b_lvl, b_lv, b_byp}), 16'(exp_eq(eb)),
      "eq b");
  endtask

  // decoded outputs land one edge after the taking edge
  task automatic wr(input logic [7:0] a, input lsc_byte_t d);
    host.write_reg(a, d);
    repeat (2) @(posedge REF_CLK);
    #1;
  endtask

  task automatic do_reset();
    RST_N <= 1'b0;
    repeat (8) @(posedge REF_CLK);
    RST_N <= 1'b1;
    @(posedge REF_CLK);
    #1;
  endtask

  task automatic chk_defaults();
    chk_eq(6'h20, 6'h20);
    chk(16'({a_dthr, a_athr, b_dthr, b_athr}), 16'h0000, "thr reset");
    chk(16'({mute, sd_en, sw_hi}), 16'h0000, "idle reset");
    chk(16'({sw1, sw2}), 16'({7'h03, 8'h03}), "swing reset");
    for (int i = 0; i < 7; i++)
      chk_rd(ofs[i], rst[i]);
  endtask

  initial
  begin
    n_mismatch = 0;
    checks = 0;
    RST_N = 1'b0;
    void'($urandom(32'hCD0F));
    do_reset();
    chk_defaults();
    // unmapped offset must not alias onto a mapped register
    wr(8'h21, 8'hA5);
    chk_rd(8'h21, `LSC_RST_UNMAPPED);
    chk_defaults();
    // all 24 levels, corners, then random fields
    for (int i = 0; i < 32; i++)
    begin
      fa = (i < 24) ? {1'b1, 5'(i)} : (i < 27) ? corner[i - 24] :
        6'($urandom);
      bb = 8'($urandom);
      wr(`LSC_OFS_IN_A_EQ, {2'h0, fa});
      wr(`LSC_OFS_IN_B_EQ, bb);
      chk_eq(fa, bb[5:0]);
      chk_rd(`LSC_OFS_IN_B_EQ, bb);
    end
    for (int i = 0; i < 16; i++)
    begin
      bb = 8'($urandom);
      wr(`LSC_OFS_IN_A_IDLE_THR, {4'h0, 4'(i)});
      wr(`LSC_OFS_IN_B_IDLE_THR, bb);
      chk(16'({a_dthr, a_athr}), 16'(i), "thr a");
      chk(16'({b_dthr, b_athr}), 16'(bb[3:0]), "thr b");
      chk_rd(`LSC_OFS_IN_B_IDLE_THR, bb);
    end
    // detector high, so manual modes must ignore it
    host.drive_idle(1'b1);
    wr(`LSC_OFS_OUT_IDLE_SEL, 8'h10);
    chk(16'({mute, sd_en}), 16'h0002, "manual mute");
    wr(`LSC_OFS_OUT_IDLE_SEL, 8'h00);
    chk(16'({mute, sd_en}), 16'h0000, "manual on");
    wr(`LSC_OFS_OUT_IDLE_SEL, 8'h30);
    chk(16'({mute, sd_en}), 16'h0003, "auto mode");
    wr(`LSC_OFS_OUT_IDLE_SEL, 8'h20);
    chk(16'({mute, sd_en}), 16'h0003, "auto select off");
    prev = 1'b1;
    for (int i = 0; i < 16; i++)
    begin
      v = 1'($urandom);
      host.drive_idle(v);
      #1;
      chk(16'(mute), 16'(prev), "auto follow");
      prev = v;
    end
    wr(`LSC_OFS_OUT_SWING_1, 8'h07);
    chk(16'({sw1, sw_hi}), 16'({7'h07, 1'b1}), "swing high");
    wr(`LSC_OFS_OUT_SWING_1, 8'h83);
    chk(16'({sw1, sw_hi}), 16'({7'h03, 1'b0}), "swing low");
    chk_rd(`LSC_OFS_OUT_SWING_1, 8'h83);
    wr(`LSC_OFS_OUT_SWING_2, 8'h01);
    chk(16'(sw2), 16'h0001, "swing second");
    bb = 8'($urandom);
    wr(`LSC_OFS_OUT_SWING_2, bb);
    chk(16'(sw2), 16'(bb), "swing second");
    chk_rd(`LSC_OFS_OUT_SWING_2, bb);
    // second reset from a non-default state
    do_reset();
    chk_defaults();
    close_out();
  end
endmodule
